//--- lts_tile.sv
// logic tile: storage pair, carry path and configuration registers on wishbone
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module lts_tile (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // wishbone classic slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [lts_pkg::LTS_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [lts_pkg::LTS_DATA_W-1:0] wb_dat_i,
  output logic [lts_pkg::LTS_DATA_W-1:0]     wb_dat_o,
  output logic                               wb_ack_o,
  // storage pins from the fabric
  input  wire logic                          tile_clock_pin_i,
  input  wire logic                          capture_allow_pin_i,
  input  wire logic                          preset_clear_pin_i,
  input  wire logic                          chip_wide_preset_pulse_i,
  input  wire logic [1:0]                    store_data_i,
  // storage outputs to the interconnect
  output logic [1:0]                         store_q_o,
  // carry operands and neighbours
  input  wire logic [1:0]                    op_a_i,
  input  wire logic [1:0]                    op_b_i,
  input  wire logic                          g_generator_fourth_input_i,
  input  wire logic                          carry_in_from_below_i,
  input  wire logic                          carry_in_from_above_i,
  // carry results
  output logic [1:0]                         sum_o,
  output logic                               carry_output_up_o,
  output logic                               carry_output_down_o,
  output logic                               carry_output_right_o,
  output logic                               carry_general_o
);
  import lts_pkg::*;

  // ****************************************
  // declarations
  // ****************************************

  // index of each pin in the synchroniser bundle
  localparam int PIN_CLK  = 0;
  localparam int PIN_EN   = 1;
  localparam int PIN_SR   = 2;
  localparam int PIN_GSR  = 3;
  localparam int PIN_D0   = 4;
  localparam int PIN_D1   = 5;
  localparam int PIN_W    = 6;

  // configuration and lock state
  lts_cfg_t                 cfg_reg;
  lts_cfg_t                 cfg_next;
  logic                     lock_reg;
  logic                     lock_next;

  // bus state
  logic                     ack_reg;
  logic [LTS_DATA_W-1:0]    rdata_reg;
  logic [LTS_DATA_W-1:0]    rdata_next;

  // pin synchronisers and edge history
  logic [PIN_W-1:0]         pin_raw;
  logic [PIN_W-1:0]         sync1_reg;
  logic [PIN_W-1:0]         sync2_reg;
  logic                     clk_prev_reg;

  // conditioned controls
  logic                     en_pin;
  logic                     sr_pin;
  logic                     gsr_pin;
  logic [1:0]               data_pin;
  logic [1:0]               elem_en;
  logic [1:0]               elem_clk_level;
  logic [1:0]               elem_clk_edge;
  logic                     clear_active;
  logic [1:0]               q_w;

  // carry results
  lts_carry_t               carry_w;
  logic [1:0]               sum_w;

  // bus decode
  logic                     bus_req;
  logic                     bus_take;
  logic                     wr_fire;
  logic                     hit_cfg;
  logic                     hit_lock;
  logic                     hit_status;
  logic [LTS_DATA_W-1:0]    status_word;
  logic [LTS_DATA_W-1:0]    cfg_merged;

  // ****************************************
  // functions
  // ****************************************

  // byte-lane merge of write data into a register word
  function automatic logic [LTS_DATA_W-1:0] lts_merge(
    input logic [LTS_DATA_W-1:0] old_w,
    input logic [LTS_DATA_W-1:0] new_w,
    input logic [3:0]            sel
  );
    logic [LTS_DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : lts_merge

  // address match on the aligned word
  function automatic logic lts_hit(
    input logic [LTS_ADDR_W-1:0] adr,
    input logic [LTS_ADDR_W-1:0] target
  );
    return adr[LTS_ADDR_W-1:2] == target[LTS_ADDR_W-1:2];
  endfunction : lts_hit

  // ****************************************
  // wishbone slave
  // ****************************************

  // request decode; one wait state, the write lands on the ack edge
  assign bus_req    = wb_cyc_i & wb_stb_i;
  assign bus_take   = bus_req & ~ack_reg;
  assign wr_fire    = bus_req & ack_reg & wb_we_i;
  assign hit_cfg    = lts_hit(wb_adr_i, LTS_ADDR_CFG);
  assign hit_lock   = lts_hit(wb_adr_i, LTS_ADDR_LOCK);
  assign hit_status = lts_hit(wb_adr_i, LTS_ADDR_STATUS);

  // live tile state seen by software
  assign status_word = {{(LTS_DATA_W - LTS_ST_LOCK_BIT - 1){1'b0}},
                        lock_reg,
                        3'h0,
                        carry_w.general,
                        sum_w,
                        q_w};

  // read mux, unmapped words read as zero
  assign rdata_next = hit_cfg    ? {{(LTS_DATA_W - LTS_CFG_W){1'b0}}, cfg_reg} :
                      hit_lock   ? {{(LTS_DATA_W - 1){1'b0}}, lock_reg} :
                      hit_status ? status_word :
                      {LTS_DATA_W{1'b0}};

  // configuration may change only until the lock is set
  assign cfg_merged = lts_merge({{(LTS_DATA_W - LTS_CFG_W){1'b0}}, cfg_reg},
                                wb_dat_i, wb_sel_i);
  assign cfg_next  = (wr_fire && hit_cfg && !lock_reg) ?                // [RQ17]
                     lts_cfg_t'(cfg_merged[LTS_CFG_W-1:0]) :
                     cfg_reg;
  // lock is sticky until reset
  assign lock_next = lock_reg |                                         // [RQ17]
                     (wr_fire && hit_lock && wb_sel_i[0] && wb_dat_i[LTS_LOCK_BIT]);

  // bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg   <= bus_take;
      rdata_reg <= bus_take ? rdata_next : rdata_reg;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg  <= LTS_CFG_RESET;
      lock_reg <= 1'b0;
    end else begin
      cfg_reg  <= cfg_next;
      lock_reg <= lock_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ****************************************
  // pin synchronisers
  // ****************************************

  // bundle of fabric pins, all passed through two flops together
  assign pin_raw = {store_data_i[1],
                    store_data_i[0],
                    chip_wide_preset_pulse_i,
                    preset_clear_pin_i,
                    capture_allow_pin_i,
                    tile_clock_pin_i};

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // previous clock level for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= sync2_reg[PIN_CLK];
    end
  end

  // ****************************************
  // control conditioning
  // ****************************************

  // synchronised pin levels
  assign en_pin    = sync2_reg[PIN_EN];   // active high, never inverted [RQ5]
  assign sr_pin    = sync2_reg[PIN_SR];
  assign gsr_pin   = sync2_reg[PIN_GSR];
  assign data_pin  = {sync2_reg[PIN_D1], sync2_reg[PIN_D0]};

  // an unconnected preset/clear pin reads low
  assign clear_active = cfg_reg.sr_used & sr_pin;                       // [RQ7]

  // per-element clock polarity and enable
  genvar e;
  generate
    for (e = 0; e < LTS_NUM_ELEM; e++) begin : g_elem_ctl
      // inversion absorbed in the tile; rising edge of the inverted level
      assign elem_clk_level[e] = sync2_reg[PIN_CLK] ^ cfg_reg.clk_inv[e];  // [RQ3]
      assign elem_clk_edge[e]  = elem_clk_level[e] &                       // [RQ3]
                                 ~(clk_prev_reg ^ cfg_reg.clk_inv[e]);
      // unconnected capture-allow counts as asserted
      assign elem_en[e]        = ~cfg_reg.en_used[e] | en_pin;            // [RQ4] [RQ5]
    end
  endgenerate

  // ****************************************
  // storage pair
  // ****************************************

  // both elements share clock and capture-allow
  generate
    for (e = 0; e < LTS_NUM_ELEM; e++) begin : g_store
      lts_store u_store (
        .clk_i        (clk_i),
        .rst_i        (rst_i),                        // power-up value [RQ6]
        .latch_mode_i (cfg_reg.latch_mode[e]),        // [RQ2]
        .init_set_i   (cfg_reg.init_set[e]),          // [RQ6]
        .preset_i     (gsr_pin),                      // [RQ6]
        .clear_i      (clear_active),                 // [RQ7]
        .enable_i     (elem_en[e]),                   // [RQ1] [RQ8]
        .clk_level_i  (elem_clk_level[e]),            // [RQ9]
        .clk_edge_i   (elem_clk_edge[e]),             // [RQ8]
        .data_i       (data_pin[e]),                  // [RQ1]
        .q_o          (q_w[e])
      );
    end
  endgenerate

  assign store_q_o = q_w;

  // ****************************************
  // carry path
  // ****************************************

  // dedicated chain between neighbouring tiles
  lts_carry u_carry (
    .cfg_i                 (cfg_reg),
    .op_a_i                (op_a_i),
    .op_b_i                (op_b_i),
    .g_fourth_i            (g_generator_fourth_input_i),
    .carry_in_from_below_i (carry_in_from_below_i),
    .carry_in_from_above_i (carry_in_from_above_i),
    .sum_o                 (sum_w),
    .carry_output_o        (carry_w)
  );

  // gated carry outputs: the value rides only on the enabled direction
  assign sum_o                = sum_w;                                   // [RQ12]
  assign carry_output_up_o    = carry_w.up & carry_w.general;            // [RQ10] [RQ15]
  assign carry_output_down_o  = carry_w.down & carry_w.general;          // [RQ13] [RQ15]
  assign carry_output_right_o = carry_w.right & carry_w.general;         // [RQ13]
  // general-routing copy for a downward carry on the upward-only variant
  assign carry_general_o      = carry_w.general;                         // [RQ14]

endmodule : lts_tile

`default_nettype wire

//--- lts_pkg.sv
// package: register map, configuration layout and carrier types for the logic tile
//
// How it works
// RQ1: Two edge-triggered storage elements share one tile clock pin and one capture-allow pin and drive their outputs out.
// RQ2: Either element can be switched into a level latch while still using the shared clock and capture-allow pins.
// RQ3: Each element has its own clock inversion bit so it triggers on the rising or the falling pin edge.
// RQ4: Capture-allow is active high and an element whose capture-allow is marked unconnected sees it always asserted.
// RQ5: Capture-allow has no per-element inversion; only its active-high sense reaches the elements.
// RQ6: Reset and the chip-wide preset pulse force each element to its chosen initial value, reset being the default; reset here loads 0, not init_set.
// RQ7: The preset/clear pin reads low when unconnected and when high forces the chosen initial value.
// RQ8: In flip-flop mode with preset/clear low and capture-allow high data is taken on the active edge, else held.
// RQ9: In latch mode with preset/clear low and capture-allow high the output follows data while clock is 0 and holds at 1.
// RQ10: Each generator pair has dedicated carry logic feeding the adjacent tile apart from general routing.
// RQ11: The two generators form a 2-bit adder with an internal carry that chains through tiles to any width.
// RQ12: The carry logic uses the generator operands and its carries return to form the sum bits.
// RQ13: The bidirectional variant carries up or down and passes the carry right at the column ends.
// RQ14: The high-capacity variant carries upward only, a downward carry going over general routing.
// RQ15: In the upward-only variant the carry leaves at the top only and the carry-in from above is absent.
// RQ16: In the upward-only variant a zero selection lets the fourth G input drive the carry output directly.
// RQ17: Mode, clock polarity, initial value and carry selections are static once configuration is locked.

package lts_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [3:0] LTS_ADDR_CFG    = 4'h0;
  localparam logic [3:0] LTS_ADDR_LOCK   = 4'h4;
  localparam logic [3:0] LTS_ADDR_STATUS = 4'h8;
  localparam int         LTS_ADDR_W      = 4;
  localparam int         LTS_DATA_W      = 32;

  // ****************************************
  // configuration field layout
  // ****************************************
  localparam int LTS_CFG_W        = 13;
  localparam int LTS_LOCK_BIT     = 0;
  localparam int LTS_NUM_ELEM     = 2;
  localparam int LTS_SYNC_STAGES  = 2;

  // configuration word, bit 0 at the bottom of the struct
  typedef struct packed {
    logic       g4_init;       // bit 12: fourth G input drives carry
    logic       column_edge;   // bit 11: no tile beyond, carry goes right
    logic       carry_down;    // bit 10: bidirectional chain runs down
    logic       up_only;       // bit 9: high-capacity upward-only variant
    logic       sr_used;       // bit 8: preset/clear pin connected
    logic [1:0] en_used;       // bits 7:6: capture-allow connected
    logic [1:0] init_set;      // bits 5:4: initial value is set
    logic [1:0] clk_inv;       // bits 3:2: clock inverted per element
    logic [1:0] latch_mode;    // bits 1:0: element is a latch
  } lts_cfg_t;

  localparam lts_cfg_t LTS_CFG_RESET = '0;

  // carry path pins toward neighbouring tiles
  typedef struct packed {
    logic up;
    logic down;
    logic right;
    logic general;
  } lts_carry_t;

  // status register layout
  localparam int LTS_ST_Q_LSB     = 0;
  localparam int LTS_ST_SUM_LSB   = 2;
  localparam int LTS_ST_CARRY_LSB = 4;
  localparam int LTS_ST_LOCK_BIT  = 8;

endpackage : lts_pkg

//--- lts_store.sv
// storage element: flip-flop or level latch with preset and enable
`timescale 1ns/10ps
`default_nettype none

module lts_store (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // configuration
  input  wire logic latch_mode_i,
  input  wire logic init_set_i,
  // conditioned controls
  input  wire logic preset_i,
  input  wire logic clear_i,
  input  wire logic enable_i,
  input  wire logic clk_level_i,
  input  wire logic clk_edge_i,
  input  wire logic data_i,
  // stored value
  output logic      q_o
);
  import lts_pkg::*;

  logic q_reg;
  logic q_next;
  logic force_init;
  logic take_data;

  // forcing beats clock, enable and data
  assign force_init = preset_i | clear_i;                                   // [RQ6] [RQ7]
  // latch opens while the clock is low, flip-flop on the active edge
  assign take_data  = enable_i & (latch_mode_i ? ~clk_level_i : clk_edge_i); // [RQ8] [RQ9]

  // next-value selection
  assign q_next = force_init ? init_set_i : (take_data ? data_i : q_reg);

  // state register, reset loads the default clear value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule : lts_store

`default_nettype wire

//--- lts_carry.sv
// dedicated 2-bit carry and sum path of the two function generators
`timescale 1ns/10ps
`default_nettype none

module lts_carry (
  // configuration
  input  wire lts_pkg::lts_cfg_t   cfg_i,
  // operands shared with the generators
  input  wire logic [1:0]          op_a_i,
  input  wire logic [1:0]          op_b_i,
  input  wire logic                g_fourth_i,
  // carry in from neighbours
  input  wire logic                carry_in_from_below_i,
  input  wire logic                carry_in_from_above_i,
  // results
  output logic [1:0]               sum_o,
  output lts_pkg::lts_carry_t      carry_output_o
);
  import lts_pkg::*;

  logic       cin;
  logic       c1;
  logic       c2;
  logic       chain_out;
  logic       to_right;

  // upward-only has no carry from above; zero select loads the fourth G input
  assign cin = cfg_i.g4_init ? g_fourth_i :                                   // [RQ16]
               (!cfg_i.up_only && cfg_i.carry_down) ? carry_in_from_above_i : // [RQ13] [RQ15]
               carry_in_from_below_i;

  // internal carry between the two generators
  assign c1 = (op_a_i[0] & op_b_i[0]) | (cin & (op_a_i[0] ^ op_b_i[0]));   // [RQ11] [RQ12]
  assign c2 = (op_a_i[1] & op_b_i[1]) | (c1 & (op_a_i[1] ^ op_b_i[1]));    // [RQ11] [RQ12]

  // carries recombine with operands to form the sums
  assign sum_o[0] = op_a_i[0] ^ op_b_i[0] ^ cin;                              // [RQ12]
  assign sum_o[1] = op_a_i[1] ^ op_b_i[1] ^ c1;                               // [RQ12]

  // zero select passes the fourth G input straight to the carry output
  assign chain_out = cfg_i.g4_init ? g_fourth_i : c2;                         // [RQ16]
  // column end on the bidirectional variant turns the chain right
  assign to_right  = !cfg_i.up_only && cfg_i.column_edge;                     // [RQ13]

  // dedicated outputs toward the adjacent tiles
  assign carry_output_o.up      = !to_right && (cfg_i.up_only || !cfg_i.carry_down); // [RQ10] [RQ15]
  assign carry_output_o.down    = !to_right && !cfg_i.up_only && cfg_i.carry_down;   // [RQ13] [RQ14]
  assign carry_output_o.right   = to_right;                                          // [RQ13]
  assign carry_output_o.general = chain_out;                                         // [RQ14]

endmodule : lts_carry

`default_nettype wire

//--- lts_nbr_model.sv
// neighbour tiles handing carries into the tile
`timescale 1ns/10ps
`default_nettype none
module lts_nbr_model (
  // carries chosen for the neighbours
  input  wire logic below_val_i,
  input  wire logic above_val_i,
  // carry pins into the tile
  output logic      carry_in_from_below_o,
  output logic      carry_in_from_above_o
);
  // neighbour carry outputs over the dedicated path
  assign carry_in_from_below_o = below_val_i;
  assign carry_in_from_above_o = above_val_i;
endmodule : lts_nbr_model
`default_nettype wire

//--- lts_tile_chk_sva.sv
// checker: bus handshake, storage forcing and carry routing
`timescale 1ns/10ps
`default_nettype none
module lts_tile_chk (
  // clock and reset
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  // bus
  input wire logic                          wb_cyc_i,
  input wire logic                          wb_stb_i,
  input wire logic                          wb_ack_o,
  input wire logic [lts_pkg::LTS_DATA_W-1:0] wb_dat_o,
  // storage
  input wire logic                          chip_wide_preset_pulse_i,
  input wire logic [1:0]                    store_q_o,
  // carry
  input wire logic                          carry_output_up_o,
  input wire logic                          carry_output_down_o,
  input wire logic                          carry_output_right_o,
  input wire logic                          carry_general_o
);
  import lts_pkg::*;
  // ****************************************
  // properties
  // ****************************************
  // request taken and any routed carry
  wire logic take_w;
  wire logic dir_w;
  assign take_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign dir_w  = carry_output_up_o | carry_output_down_o | carry_output_right_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_after_take; take_w |=> wb_ack_o; endproperty
  a_ack_after_take: assert property (p_ack_after_take) else $error("no ack after take");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_no_stray_ack; !take_w |=> !wb_ack_o; endproperty
  a_no_stray_ack: assert property (p_no_stray_ack) else $error("ack without request");
  property p_dat_hold; !take_w |=> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_dir_onehot;
    $onehot0({carry_output_up_o, carry_output_down_o, carry_output_right_o});
  endproperty
  a_dir_onehot: assert property (p_dir_onehot) else $error("carry on two paths");
  property p_dir_general; dir_w |-> carry_general_o; endproperty
  a_dir_general: assert property (p_dir_general) else $error("routed carry differs");
  property p_gsr_hold;
    chip_wide_preset_pulse_i [*4] |=> $stable(store_q_o);
  endproperty
  a_gsr_hold: assert property (p_gsr_hold) else $error("q moved under preset");
  property p_rst_clears;
    disable iff (1'b0) rst_i |=> (store_q_o == 2'h0) && !wb_ack_o;
  endproperty
  a_rst_clears: assert property (p_rst_clears) else $error("reset not cleared");
endmodule : lts_tile_chk
bind lts_tile lts_tile_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .chip_wide_preset_pulse_i(chip_wide_preset_pulse_i), .store_q_o(store_q_o),
  .carry_output_up_o(carry_output_up_o), .carry_output_down_o(carry_output_down_o),
  .carry_output_right_o(carry_output_right_o), .carry_general_o(carry_general_o));
`default_nettype wire

//--- lts_tile_tb_top.sv
// testbench: storage pair, carry rows and register bus of the tile
`timescale 1ns/10ps
`default_nettype none
module lts_tile_tb_top;
  import lts_pkg::*;
  // carry row: configuration, operands, expected sum and {up,down,right,general}
  typedef struct packed {
    logic [12:0] cfg;
    logic [1:0]  a;
    logic [1:0]  b;
    logic        g4;
    logic        cb;
    logic        ca;
    logic [1:0]  sum;
    logic [3:0]  dir;
  } lts_row_t;
  logic        clk_i, rst_i, cyc, stb, we, ack, tclk, cap, psr, chip_wide_preset_pulse, g4, nb_lo, nb_hi;
  logic        up, dn, rt, gen, cin_lo, cin_hi;
  logic [3:0]  adr;
  logic [31:0] wdat, rd, dat_o;
  logic [1:0]  d, q, a, b, sum;
  int          fails, tests_run, cycles;
  lts_row_t    rows [6];
  // ****************************************
  // clock, design and neighbours
  // ****************************************
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  lts_tile dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .tile_clock_pin_i(tclk), .capture_allow_pin_i(cap), .preset_clear_pin_i(psr),
    .chip_wide_preset_pulse_i(chip_wide_preset_pulse), .store_data_i(d), .store_q_o(q), .op_a_i(a),
    .op_b_i(b), .g_generator_fourth_input_i(g4), .carry_in_from_below_i(cin_lo),
    .carry_in_from_above_i(cin_hi), .sum_o(sum), .carry_output_up_o(up),
    .carry_output_down_o(dn), .carry_output_right_o(rt), .carry_general_o(gen));
  lts_nbr_model nbr (.below_val_i(nb_lo), .above_val_i(nb_hi),
    .carry_in_from_below_o(cin_lo), .carry_in_from_above_o(cin_hi));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] dt);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {1'h1, 1'h1, w, ad, dt};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'h1);
    rd = dat_o;
    {cyc, stb, we} <= 3'h0;
  endtask : wb
  // pins {preset pulse, preset/clear, capture allow, tile clock} then settle
  task automatic pins(input logic [3:0] ctl, input logic [1:0] dd);
    @(posedge clk_i);
    {chip_wide_preset_pulse, psr, cap, tclk} <= ctl;
    d <= dd;
    repeat (6) @(posedge clk_i);
  endtask : pins
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    {cyc, stb, we, adr, wdat, tclk, cap, psr, chip_wide_preset_pulse, d, a, b, g4, nb_lo, nb_hi} = '0;
    rst_i = 1'h1;
    {fails, tests_run, cycles} = '0;
    rows[0] = '{13'h000, 2'h1, 2'h3, 1'h0, 1'h0, 1'h0, 2'h0, 4'h9};
    rows[1] = '{13'h400, 2'h2, 2'h1, 1'h0, 1'h0, 1'h1, 2'h0, 4'h5};
    rows[2] = '{13'h800, 2'h3, 2'h1, 1'h0, 1'h0, 1'h0, 2'h0, 4'h3};
    rows[3] = '{13'h600, 2'h3, 2'h0, 1'h0, 1'h1, 1'h0, 2'h0, 4'h9};
    rows[4] = '{13'h1200, 2'h0, 2'h0, 1'h1, 1'h0, 1'h0, 2'h1, 4'h9};
    rows[5] = '{13'h000, 2'h1, 2'h2, 1'h0, 1'h0, 1'h1, 2'h3, 4'h0};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    chk("q_reset", 32'h0, 32'(q));
    wb(1'h0, LTS_ADDR_CFG, 32'h0);
    chk("cfg_reset", 32'h0, rd);
    foreach (rows[i]) begin
      wb(1'h1, LTS_ADDR_CFG, 32'(rows[i].cfg));
      {a, b, g4, nb_lo, nb_hi} <= {rows[i].a, rows[i].b, rows[i].g4, rows[i].cb, rows[i].ca};
      @(posedge clk_i);
      @(posedge clk_i);
      chk("sum", 32'(rows[i].sum), 32'(sum));
      chk("dir", 32'(rows[i].dir), 32'({up, dn, rt, gen}));
    end
    pins(4'h2, 2'h1);
    pins(4'h3, 2'h1);
    chk("q_ff", 32'h1, 32'(q));
    wb(1'h1, LTS_ADDR_CFG, 32'h0C8);
    pins(4'h0, 2'h2);
    pins(4'h1, 2'h2);
    chk("q_en_low", 32'h1, 32'(q));
    pins(4'h2, 2'h2);
    chk("q_fall", 32'h3, 32'(q));
    pins(4'h3, 2'h2);
    chk("q_rise", 32'h2, 32'(q));
    wb(1'h1, LTS_ADDR_CFG, 32'h003);
    pins(4'h2, 2'h1);
    chk("q_latch_open", 32'h1, 32'(q));
    pins(4'h3, 2'h1);
    pins(4'h3, 2'h2);
    chk("q_latch_shut", 32'h1, 32'(q));
    wb(1'h1, LTS_ADDR_CFG, 32'h0C3);
    pins(4'h0, 2'h2);
    chk("q_latch_en", 32'h1, 32'(q));
    wb(1'h1, LTS_ADDR_CFG, 32'h130);
    pins(4'h6, 2'h0);
    chk("q_sr", 32'h3, 32'(q));
    pins(4'h2, 2'h0);
    pins(4'h3, 2'h0);
    chk("q_after_sr", 32'h0, 32'(q));
    wb(1'h1, LTS_ADDR_CFG, 32'h030);
    pins(4'h7, 2'h0);
    chk("q_sr_unused", 32'h0, 32'(q));
    pins(4'hB, 2'h0);
    chk("q_gsr", 32'h3, 32'(q));
    pins(4'h3, 2'h0);
    wb(1'h1, LTS_ADDR_LOCK, 32'h1);
    wb(1'h1, LTS_ADDR_CFG, 32'h400);
    wb(1'h0, LTS_ADDR_CFG, 32'h0);
    chk("cfg_locked", 32'h030, rd);
    wb(1'h0, LTS_ADDR_STATUS, 32'h0);
    chk("lock_bit", 32'h1, 32'(rd[LTS_ST_LOCK_BIT]));
    chk("status", 32'h10F, rd);
    wb(1'h0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, rd);
    // mid-run reset clears elements, configuration and lock
    rst_i <= 1'h1;
    @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, LTS_ADDR_STATUS, 32'h0);
    chk("status_reset", 32'h00C, rd);
    stop_test();
  end
endmodule : lts_tile_tb_top
`default_nettype wire
